// ===== rtl/swpf_pkg.sv
// package: register map, timing counts and state types of the sleep and power-fail logic
// What this block does
// - wake pin wakes any Sx, no status
// - or all pme messages into one status
// - pme status with enable raises sci
// - power return state follows loss policy bit
// - button status cleared while deep power low
// - alarm enable kept, alarm status cleared
// - power-good falls set two failure flags
// - pme cannot wake after loss; reset clears
// - deep entry needs engine off plus policy
// - warn, wait acknowledge, then sleep suspend well
// - enabled deep wake releases suspend well
// - deep wakes: alarm, button, pin, wake alarm
// - ac rise leaves battery-only deep, stays Sx
// - ac fall after that re-enters deep
// - engine-enabled ac acts as engine wake
// - button debounced by 16 ms filter
// - falling edges ignored 16 ms or 500 us
// - stretch holds wake; pending press wakes later
// - override stretched to 9 s during stretch
// - extend only after graceful entry, not power-up
// - four second hold forces S5 from S0 or Sx, not from warn or deep
package swpf_pkg;

    // =========================================
    // timing
    localparam int unsigned CLK_MHZ = 100;
    localparam int unsigned PB_DEB_MS = 16;
    localparam int unsigned PB_FAST_US = 500;
    localparam int unsigned OVR_SHORT_S = 4;
    localparam int unsigned OVR_LONG_S = 9;
    localparam int unsigned PB_DEB_CYC = PB_DEB_MS * CLK_MHZ * 1000;
    localparam int unsigned PB_FAST_CYC = PB_FAST_US * CLK_MHZ;
    localparam int unsigned OVR_SHORT_CYC = OVR_SHORT_S * CLK_MHZ * 1000000;
    localparam int unsigned OVR_LONG_CYC = OVR_LONG_S * CLK_MHZ * 1000000;

    // =========================================
    // register offsets
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_STAT = 8'h04;
    localparam logic [7:0] OFF_CMD = 8'h08;
    localparam logic [7:0] OFF_STATE = 8'h0C;
    localparam logic [31:0] CTRL_RST = 32'h00000000;
    localparam logic [31:0] CTRL_MASK = 32'h00203FFF;

    // =========================================
    // control fields
    localparam int C_AFTER = 0;
    localparam int C_DBMODE = 1;
    localparam int C_POL = 2;
    localparam int C_PCIEN = 8;
    localparam int C_PMEEN = 9;
    localparam int C_RTCEN = 10;
    localparam int C_WAKDIS = 11;
    localparam int C_WADT = 12;
    localparam int C_MEAC = 13;
    localparam int C_RTCDS = 21;

    // =========================================
    // status fields, write one to clear
    localparam int S_PCIE = 0;
    localparam int S_PB = 1;
    localparam int S_RTC = 2;
    localparam int S_CFLR = 3;
    localparam int S_DFLR = 4;
    localparam int S_PME = 5;
    localparam int S_GPE = 6;
    localparam int STAT_W = 7;

    // =========================================
    // command fields and sleep codes
    localparam int K_CYC = 2;
    localparam logic [1:0] SX_S0 = 2'h0;
    localparam logic [1:0] SX_S3 = 2'h1;
    localparam logic [1:0] SX_S4 = 2'h2;
    localparam logic [1:0] SX_S5 = 2'h3;

    typedef enum logic [2:0] {ST_G3, ST_S0, ST_SX, ST_WARN, ST_DEEP} swpf_state_t;

endpackage : swpf_pkg

// ===== rtl/swpf_sync3.sv
// module: three-flop pin synchroniser that accepts a level once two stages agree
`timescale 1ns/1ns
`default_nettype none

module swpf_sync3 #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // pins and clean levels
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    logic [W-1:0] ff1_reg;
    logic [W-1:0] ff2_reg;
    logic [W-1:0] ff3_reg;
    logic [W-1:0] q_reg;
    logic [W-1:0] q_next;
    logic [W-1:0] agree;

    // take a bit only where stages two and three agree
    always_comb begin
        agree = ff2_reg ~^ ff3_reg;
        q_next = (q_reg & ~agree) | (ff2_reg & agree);
    end

    // stage chain
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ff1_reg <= INIT;
            ff2_reg <= INIT;
            ff3_reg <= INIT;
            q_reg <= INIT;
        end else begin
            ff1_reg <= d;
            ff2_reg <= ff1_reg;
            ff3_reg <= ff2_reg;
            q_reg <= q_next;
        end
    end

    assign q = q_reg;

endmodule : swpf_sync3

`default_nettype wire

// ===== rtl/swpf_ctrl.sv
// module: sleep state, deep sleep and power-fail controller with button filter
//
// The address map and the address-and-strobe port were decided locally.
`timescale 1ns/1ns
`default_nettype none

module swpf_ctrl
    import swpf_pkg::*;
#(
    parameter int unsigned DEB_CYC = PB_DEB_CYC,
    parameter int unsigned FAST_CYC = PB_FAST_CYC,
    parameter int unsigned OVR_SHORT = OVR_SHORT_CYC,
    parameter int unsigned OVR_LONG = OVR_LONG_CYC,
    parameter int PME_PORTS = 4
) (
    // clock and rtc-well reset
    input wire logic clk,
    input wire logic nrst,
    // register port
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // power pins
    input wire logic core_power_good,
    input wire logic deep_well_power_good,
    input wire logic resume_well_reset_n,
    // wake pins
    input wire logic power_button_n,
    input wire logic pcie_wake_n,
    input wire logic pme_n,
    input wire logic rtc_alarm,
    input wire logic wake_alarm_event,
    input wire logic ac_adapter_present,
    // platform handshake
    input wire logic suspend_acknowledge_n,
    output logic suspend_warning_n,
    output logic suspend_well_sleep_n,
    // on-chip sources
    input wire logic [PME_PORTS-1:0] pme_msg_ports,
    input wire logic pme_msg_cpu,
    input wire logic me_off,
    input wire logic stretch_active,
    // sleep outputs and event
    output logic sleep_s3_n,
    output logic sleep_s4_n,
    output logic sleep_s5_n,
    output logic sci
);

    // =========================================
    // pin synchronisers
    localparam int P_PB = 0;
    localparam int P_WAKE = 1;
    localparam int P_PME = 2;
    localparam int P_RTC = 3;
    localparam int P_WADT = 4;
    localparam int P_AC = 5;
    localparam int P_ACK = 6;
    localparam int P_CPG = 7;
    localparam int P_DPG = 8;
    localparam int P_RSM = 9;
    localparam int NPIN = 10;
    localparam logic [NPIN-1:0] PIN_IDLE = 10'h047;

    logic [NPIN-1:0] pin_s;
    logic [NPIN-1:0] prev_reg;

    swpf_sync3 #(.W(NPIN), .INIT(PIN_IDLE)) u_sync (
        .clk(clk),
        .nrst(nrst),
        .d({resume_well_reset_n, deep_well_power_good, core_power_good,
            suspend_acknowledge_n, ac_adapter_present, wake_alarm_event,
            rtc_alarm, pme_n, pcie_wake_n, power_button_n}),
        .q(pin_s)
    );

    // deep policy of one sleep state under the present supply
    function automatic logic deep_pol(input logic [5:0] pol, input logic [1:0] sx,
                                      input logic ac);
        logic dc_en;
        logic ac_en;
        dc_en = 1'b0;
        ac_en = 1'b0;
        case (sx)
            SX_S3: begin
                dc_en = pol[0];
                ac_en = pol[1];
            end
            SX_S4: begin
                dc_en = pol[2];
                ac_en = pol[3];
            end
            SX_S5: begin
                dc_en = pol[4];
                ac_en = pol[5];
            end
            default: begin
                dc_en = 1'b0;
                ac_en = 1'b0;
            end
        endcase
        return ac_en | (~ac & dc_en);
    endfunction : deep_pol

    // =========================================
    // edges of clean levels
    logic pb_raw_fall;
    logic rtc_rise;
    logic pme_fall;
    logic ac_rise;
    logic cpg_fall;
    logic dpg_fall;

    assign pb_raw_fall = prev_reg[P_PB] & ~pin_s[P_PB];
    assign rtc_rise = ~prev_reg[P_RTC] & pin_s[P_RTC];
    assign pme_fall = prev_reg[P_PME] & ~pin_s[P_PME];
    assign ac_rise = ~prev_reg[P_AC] & pin_s[P_AC];
    assign cpg_fall = prev_reg[P_CPG] & ~pin_s[P_CPG];
    assign dpg_fall = prev_reg[P_DPG] & ~pin_s[P_DPG];

    // =========================================
    // registers of all groups
    logic [31:0] ctrl_reg, ctrl_next;
    logic [STAT_W-1:0] stat_reg, stat_next;
    logic [31:0] rdata_reg, rdata_next;
    logic pb_deb_reg, pb_deb_next;
    logic [31:0] deb_cnt_reg, deb_cnt_next;
    logic [31:0] lock_cnt_reg, lock_cnt_next;
    logic [31:0] ovr_cnt_reg, ovr_cnt_next;
    logic pb_pend_reg, pb_pend_next;
    swpf_state_t state_reg, state_next;
    logic [1:0] sx_reg, sx_next;
    logic [2:0] lost_reg, lost_next;
    logic ext_reg, ext_next;
    logic pmeblk_reg, pmeblk_next;
    logic wpend_reg, wpend_next;
    logic [5:0] out_reg, out_next;

    logic dbmode;
    logic press;
    logic pb_level;
    logic ovr_fire;
    logic [31:0] ovr_lim;
    logic wr_ctrl, wr_stat, wr_cmd;
    logic host_wake;
    logic deep_wake;
    logic ac_exit;

    assign dbmode = ctrl_reg[C_DBMODE];
    assign wr_ctrl = reg_wr && (reg_addr == OFF_CTRL);
    assign wr_stat = reg_wr && (reg_addr == OFF_STAT);
    assign wr_cmd = reg_wr && (reg_addr == OFF_CMD);

    // =========================================
    // power button filter, lockout and override
    always_comb begin
        logic cand;
        cand = 1'b0;
        pb_deb_next = pb_deb_reg;
        deb_cnt_next = 32'h00000000;
        if (pin_s[P_PB] != pb_deb_reg) begin
            if (deb_cnt_reg >= DEB_CYC - 1) begin
                pb_deb_next = pin_s[P_PB];
            end else begin
                deb_cnt_next = deb_cnt_reg + 32'h00000001;
            end
        end
        // fast mode acts before the filter
        cand = dbmode ? pb_raw_fall : (pb_deb_reg & ~pb_deb_next);
        press = cand && (lock_cnt_reg == 32'h00000000) && pin_s[P_DPG];
        if (press) begin
            lock_cnt_next = dbmode ? FAST_CYC : DEB_CYC;
        end else if (lock_cnt_reg != 32'h00000000) begin
            lock_cnt_next = lock_cnt_reg - 32'h00000001;
        end else begin
            lock_cnt_next = lock_cnt_reg;
        end
        pb_level = dbmode ? pin_s[P_PB] : pb_deb_reg;
        // long limit only while stretching after a graceful entry
        ovr_lim = (stretch_active && ext_reg) ? OVR_LONG : OVR_SHORT;
        ovr_fire = 1'b0;
        ovr_cnt_next = 32'h00000000;
        if (!pb_deb_reg && (state_reg == ST_S0 ||
            (state_reg == ST_SX && sx_reg != SX_S5))) begin
            ovr_cnt_next = ovr_cnt_reg + 32'h00000001;
            ovr_fire = (ovr_cnt_reg >= ovr_lim - 1);
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pb_deb_reg <= 1'b1;
            deb_cnt_reg <= 32'h00000000;
            lock_cnt_reg <= 32'h00000000;
            ovr_cnt_reg <= 32'h00000000;
            prev_reg <= PIN_IDLE;
        end else begin
            pb_deb_reg <= pb_deb_next;
            deb_cnt_reg <= deb_cnt_next;
            lock_cnt_reg <= lock_cnt_next;
            ovr_cnt_reg <= ovr_cnt_next;
            prev_reg <= pin_s;
        end
    end

    // =========================================
    // control and sticky status, set beats clear
    always_comb begin
        logic [STAT_W-1:0] set_v;
        logic [STAT_W-1:0] clr_v;
        set_v = '0;
        clr_v = wr_stat ? reg_wdata[STAT_W-1:0] : '0;
        ctrl_next = wr_ctrl ? (reg_wdata & CTRL_MASK) : ctrl_reg;
        set_v[S_PCIE] = (|pme_msg_ports) | pme_msg_cpu;
        set_v[S_PB] = press;
        set_v[S_RTC] = rtc_rise;
        set_v[S_CFLR] = cpg_fall;
        set_v[S_DFLR] = dpg_fall;
        set_v[S_PME] = pme_fall;
        set_v[S_GPE] = stat_reg[S_PCIE] & ctrl_reg[C_PCIEN];
        stat_next = (stat_reg & ~clr_v) | set_v;
        if (!pin_s[P_DPG]) begin
            stat_next[S_PB] = 1'b0;
            stat_next[S_RTC] = 1'b0;
        end
        if (!pin_s[P_RSM]) begin
            stat_next[S_PME] = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ctrl_reg <= CTRL_RST;
            stat_reg <= '0;
        end else begin
            ctrl_reg <= ctrl_next;
            stat_reg <= stat_next;
        end
    end

    // =========================================
    // wake qualification
    always_comb begin
        host_wake = pb_pend_reg | wpend_reg | ~pin_s[P_WAKE]
            | (stat_reg[S_RTC] & ctrl_reg[C_RTCEN])
            | (stat_reg[S_PME] & ctrl_reg[C_PMEEN] & ~pmeblk_reg);
        deep_wake = press
            | (stat_reg[S_RTC] & ~ctrl_reg[C_RTCDS])
            | (~pin_s[P_WAKE] & ~ctrl_reg[C_WAKDIS])
            | (pin_s[P_WADT] & ctrl_reg[C_WADT]);
        ac_exit = ac_rise & (ctrl_reg[C_MEAC]
            | ~deep_pol(ctrl_reg[C_POL+5:C_POL], sx_reg, 1'b1));
    end

    // =========================================
    // sleep state machine
    always_comb begin
        logic [1:0] tgt;
        tgt = reg_wdata[1:0];
        state_next = state_reg;
        sx_next = sx_reg;
        lost_next = lost_reg;
        ext_next = ext_reg;
        pmeblk_next = pmeblk_reg;
        wpend_next = wpend_reg;
        pb_pend_next = pb_pend_reg | (press && state_reg != ST_S0);
        case (state_reg)
            ST_G3: begin
                pb_pend_next = 1'b0;
                if (pin_s[P_DPG]) begin
                    ext_next = 1'b0;
                    pmeblk_next = 1'b1;
                    if (!ctrl_reg[C_AFTER]) begin
                        state_next = ST_S0;
                        sx_next = SX_S0;
                    end else if (lost_reg[2]) begin
                        state_next = ST_DEEP;
                        sx_next = lost_reg[1:0];
                    end else begin
                        state_next = ST_SX;
                        sx_next = (lost_reg[1:0] == SX_S4) ? SX_S4 : SX_S5;
                    end
                end
            end
            ST_S0: begin
                pb_pend_next = 1'b0;
                if (ovr_fire) begin
                    state_next = ST_SX;
                    sx_next = SX_S5;
                end else if (wr_cmd && tgt != SX_S0) begin
                    state_next = ST_SX;
                    sx_next = tgt;
                    ext_next = 1'b1;
                    wpend_next = reg_wdata[K_CYC];
                end
            end
            ST_SX: begin
                if (ovr_fire) begin
                    sx_next = SX_S5;
                    pb_pend_next = 1'b0;
                    wpend_next = 1'b0;
                end else if (host_wake) begin
                    if (!stretch_active) begin
                        state_next = ST_S0;
                        sx_next = SX_S0;
                        pmeblk_next = 1'b0;
                        wpend_next = 1'b0;
                    end
                end else if (me_off &&
                             deep_pol(ctrl_reg[C_POL+5:C_POL], sx_reg, pin_s[P_AC])) begin
                    state_next = ST_WARN;
                end
            end
            ST_WARN: begin
                if (host_wake || !me_off) begin
                    state_next = ST_SX;
                end else if (!pin_s[P_ACK]) begin
                    state_next = ST_DEEP;
                end
            end
            ST_DEEP: begin
                if (deep_wake) begin
                    state_next = ST_SX;
                    ext_next = 1'b0;
                    wpend_next = 1'b1;
                end else if (ac_exit) begin
                    state_next = ST_SX;
                    ext_next = 1'b0;
                end
            end
            default: begin
                state_next = ST_G3;
            end
        endcase
        // deep well power loss wins over everything
        if (!pin_s[P_DPG] && state_reg != ST_G3) begin
            state_next = ST_G3;
            lost_next = {(state_reg == ST_DEEP || state_reg == ST_WARN), sx_reg};
            wpend_next = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_reg <= ST_G3;
            sx_reg <= SX_S0;
            lost_reg <= 3'h0;
            ext_reg <= 1'b0;
            pmeblk_reg <= 1'b1;
            wpend_reg <= 1'b0;
            pb_pend_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            sx_reg <= sx_next;
            lost_reg <= lost_next;
            ext_reg <= ext_next;
            pmeblk_reg <= pmeblk_next;
            wpend_reg <= wpend_next;
            pb_pend_reg <= pb_pend_next;
        end
    end

    // =========================================
    // registered pins and read data
    always_comb begin
        logic asleep;
        asleep = (state_next != ST_S0);
        out_next[0] = ~(state_next == ST_WARN || state_next == ST_DEEP);
        out_next[1] = ~(state_next == ST_DEEP || state_next == ST_G3);
        out_next[2] = ~asleep;
        out_next[3] = ~(asleep && (sx_next == SX_S4 || sx_next == SX_S5));
        out_next[4] = ~(asleep && sx_next == SX_S5);
        out_next[5] = stat_reg[S_GPE];
        rdata_next = 32'h00000000;
        if (reg_rd) begin
            case (reg_addr)
                OFF_CTRL: rdata_next = ctrl_reg;
                OFF_STAT: rdata_next = {{(32-STAT_W){1'b0}}, stat_reg};
                OFF_STATE: rdata_next = {25'h0000000, pb_level, stretch_active && ext_reg,
                                         state_reg, sx_reg};
                default: rdata_next = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            out_reg <= 6'h1F;
            rdata_reg <= 32'h00000000;
        end else begin
            out_reg <= out_next;
            rdata_reg <= rdata_next;
        end
    end

    assign suspend_warning_n = out_reg[0];
    assign suspend_well_sleep_n = out_reg[1];
    assign sleep_s3_n = out_reg[2];
    assign sleep_s4_n = out_reg[3];
    assign sleep_s5_n = out_reg[4];
    assign sci = out_reg[5];
    assign reg_rdata = rdata_reg;

endmodule : swpf_ctrl

`default_nettype wire

// ===== tb/swpf_ctrl_props.sv
// checker: port-level assertions for the sleep and power-fail controller
`timescale 1ns/1ns
`default_nettype none

module swpf_ctrl_chk
    import swpf_pkg::*;
(
    // clock, reset and register port
    input wire logic clk,
    input wire logic nrst,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    // pins and outputs
    input wire logic deep_well_power_good,
    input wire logic power_button_n,
    input wire logic pcie_wake_n,
    input wire logic rtc_alarm,
    input wire logic wake_alarm_event,
    input wire logic ac_adapter_present,
    input wire logic suspend_acknowledge_n,
    input wire logic me_off,
    input wire logic suspend_warning_n,
    input wire logic suspend_well_sleep_n,
    input wire logic sleep_s3_n,
    input wire logic sci
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    // any deep wake source, and a software clear of the event bit
    wire logic any_wake = !power_button_n || !pcie_wake_n || rtc_alarm || wake_alarm_event
        || ac_adapter_present;
    wire logic gpe_clr = reg_wr && reg_addr == OFF_STAT && reg_wdata[S_GPE];
    // =========================================
    // deep entry steps
    sequence s_sus_off;
        $fell(suspend_well_sleep_n) && $past(nrst) && deep_well_power_good
            && $past(deep_well_power_good, 4);
    endsequence
    sequence s_acked;
        !suspend_warning_n && !$past(suspend_acknowledge_n, 3);
    endsequence
    a_deep_after_ack: assert property (s_sus_off |-> s_acked)
        else $error("suspend well slept without warning and acknowledge");
    a_warn_holds_sleep: assert property (!suspend_warning_n && suspend_well_sleep_n
        && suspend_acknowledge_n && $past(suspend_acknowledge_n) && deep_well_power_good
        |=> suspend_well_sleep_n) else $error("suspend well slept before acknowledge");
    a_warn_needs_engine: assert property ($fell(suspend_warning_n) |-> $past(me_off))
        else $error("warning raised with engine on");
    a_warn_in_sleep: assert property (!suspend_warning_n |-> !sleep_s3_n)
        else $error("warning raised outside a sleep state");
    a_exit_has_cause: assert property ($rose(suspend_well_sleep_n)
        && !$past(suspend_warning_n) |-> $past(any_wake, 5))
        else $error("deep exit without a wake source");
    a_exit_drops_warn: assert property ($rose(suspend_well_sleep_n) |-> suspend_warning_n)
        else $error("warning still low after deep exit");
    a_sci_sticky: assert property (sci && !gpe_clr && !$past(gpe_clr) |=> sci)
        else $error("sci dropped without a clear");
    a_read_one_cycle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data outside the read answer cycle");
endmodule : swpf_ctrl_chk

bind swpf_ctrl swpf_ctrl_chk u_swpf_ctrl_chk (.clk, .nrst, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .deep_well_power_good, .power_button_n, .pcie_wake_n, .rtc_alarm,
    .wake_alarm_event, .ac_adapter_present, .suspend_acknowledge_n, .me_off,
    .suspend_warning_n, .suspend_well_sleep_n, .sleep_s3_n, .sci);
`default_nettype wire

// ===== tb/swpf_plat_model.sv
// partner: platform controller answering the suspend warning, never using powerdown ack
`timescale 1ns/1ns
`default_nettype none

module swpf_plat_model (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // handshake
    input wire logic suspend_warning_n,
    input wire logic slow,
    output logic suspend_acknowledge_n
);
    int cnt;
    // acknowledge once warning has stood a prompt or slow delay; pull-up when idle
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt <= 0;
            suspend_acknowledge_n <= 1'b1;
        end else if (suspend_warning_n) begin
            cnt <= 0;
            suspend_acknowledge_n <= 1'b1;
        end else if (cnt < (slow ? 20 : 2)) begin
            cnt <= cnt + 1;
        end else begin
            suspend_acknowledge_n <= 1'b0;
        end
    end
endmodule : swpf_plat_model
`default_nettype wire

// ===== tb/tb_top.sv
// testbench: register-driven scenarios for the sleep and power-fail controller
`timescale 1ns/1ns
`default_nettype none

module tb_top
    import swpf_pkg::*;
;
    logic clk = 1'b0, nrst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, slow = 1'b0;
    logic core_power_good = 1'b0, deep_well_power_good = 1'b0, resume_well_reset_n = 1'b1;
    logic power_button_n = 1'b1, pcie_wake_n = 1'b1, pme_n = 1'b1, rtc_alarm = 1'b0;
    logic wake_alarm_event = 1'b0, ac_adapter_present = 1'b0, pme_msg_cpu = 1'b0;
    logic me_off = 1'b0, stretch_active = 1'b0, suspend_acknowledge_n, suspend_warning_n;
    logic suspend_well_sleep_n, sleep_s3_n, sleep_s4_n, sleep_s5_n, sci;
    logic [ADDR_W-1:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0, reg_rdata, d = 32'h0;
    logic [3:0] pme_msg_ports = 4'h0;
    int err_count = 0, n_tests = 0;

    swpf_ctrl #(.DEB_CYC(8), .FAST_CYC(4), .OVR_SHORT(40), .OVR_LONG(90), .PME_PORTS(4))
    u_swpf_ctrl (.clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .core_power_good, .deep_well_power_good, .resume_well_reset_n, .power_button_n,
        .pcie_wake_n, .pme_n, .rtc_alarm, .wake_alarm_event, .ac_adapter_present,
        .suspend_acknowledge_n, .suspend_warning_n, .suspend_well_sleep_n, .pme_msg_ports,
        .pme_msg_cpu, .me_off, .stretch_active, .sleep_s3_n, .sleep_s4_n, .sleep_s5_n, .sci);
    swpf_plat_model u_swpf_plat_model (.clk, .nrst, .suspend_warning_n, .slow,
        .suspend_acknowledge_n);

    // 100 MHz clock
    initial begin
        forever #5 clk = ~clk;
    end

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch %s exp %h seen %h", nm, exp, seen);
        end
    endtask : chk
    // one-cycle write strobe
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr
    // one-cycle read strobe, data taken in the answer cycle
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd
    task automatic rc(input logic [7:0] a, input logic [31:0] e, input string nm);
        rd(a);
        chk(nm, d, e);
    endtask : rc
    // poll the state field until it matches, bounded
    task automatic wst(input logic [2:0] e, input string nm);
        rd(OFF_STATE);
        for (int i = 0; i < 400 && d[4:2] !== e; i++) begin
            rd(OFF_STATE);
        end
        chk(nm, {29'h0, d[4:2]}, {29'h0, e});
    endtask : wst
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : tally_and_finish

    // watchdog against a hang
    initial begin
        repeat (30000) @(posedge clk);
        err_count++;
        tally_and_finish();
    end

    // main sequence
    initial begin
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        repeat (4) @(posedge clk);
        rc(OFF_STATE, 32'h40, "g3 state");
        deep_well_power_good <= 1'b1;
        core_power_good <= 1'b1;
        wst(3'd1, "boot to s0");
        wr(OFF_CTRL, 32'h100);
        pme_msg_cpu <= 1'b1;
        @(posedge clk);
        pme_msg_cpu <= 1'b0;
        pme_msg_ports <= 4'h8;
        @(posedge clk);
        pme_msg_ports <= 4'h0;
        rc(OFF_STAT, 32'h41, "pme status");
        chk("sci", {31'h0, sci}, 32'h1);
        wr(OFF_STAT, 32'h41);
        wr(OFF_STAT, 32'h40);
        rc(OFF_STAT, 32'h0, "status cleared");
        pme_n <= 1'b0;
        repeat (6) @(posedge clk);
        rc(OFF_STAT, 32'h20, "pme wake status");
        resume_well_reset_n <= 1'b0;
        repeat (6) @(posedge clk);
        resume_well_reset_n <= 1'b1;
        pme_n <= 1'b1;
        rc(OFF_STAT, 32'h0, "resume reset clear");
        power_button_n <= 1'b0;
        repeat (3) @(posedge clk);
        power_button_n <= 1'b1;
        repeat (12) @(posedge clk);
        rc(OFF_STAT, 32'h0, "short press");
        wr(OFF_CTRL, 32'h0);
        power_button_n <= 1'b0;
        repeat (80) @(posedge clk);
        power_button_n <= 1'b1;
        wst(3'd2, "override");
        chk("override sx", {30'h0, d[1:0]}, 32'h3);
        chk("s4 s5 pins", {30'h0, sleep_s4_n, sleep_s5_n}, 32'h0);
        rc(OFF_STAT, 32'h2, "button status");
        stretch_active <= 1'b1;
        repeat (20) @(posedge clk);
        power_button_n <= 1'b0;
        repeat (20) @(posedge clk);
        power_button_n <= 1'b1;
        repeat (20) @(posedge clk);
        rc(OFF_STATE, 32'h4B, "stretch hold");
        stretch_active <= 1'b0;
        wst(3'd1, "wake after stretch");
        wr(OFF_STAT, 32'h7F);
        wr(OFF_CTRL, 32'hC0);
        me_off <= 1'b1;
        slow <= 1'b1;
        wr(OFF_CMD, 32'h3);
        wst(3'd4, "deep entry");
        pcie_wake_n <= 1'b0;
        wst(3'd1, "pin wake");
        pcie_wake_n <= 1'b1;
        rc(OFF_STAT, 32'h0, "pin no status");
        slow <= 1'b0;
        wr(OFF_CTRL, 32'h40);
        wr(OFF_CMD, 32'h3);
        wst(3'd4, "battery deep");
        ac_adapter_present <= 1'b1;
        wst(3'd2, "ac exit");
        ac_adapter_present <= 1'b0;
        wst(3'd4, "ac drop");
        wr(OFF_CTRL, 32'h2000C1);
        rtc_alarm <= 1'b1;
        repeat (10) @(posedge clk);
        rc(OFF_STATE, 32'h53, "alarm wake off");
        rc(OFF_STAT, 32'h4, "alarm status");
        deep_well_power_good <= 1'b0;
        core_power_good <= 1'b0;
        repeat (8) @(posedge clk);
        rc(OFF_STAT, 32'h18, "loss flags");
        rc(OFF_CTRL, 32'h2000C1, "ctrl kept");
        deep_well_power_good <= 1'b1;
        core_power_good <= 1'b1;
        rtc_alarm <= 1'b0;
        wst(3'd4, "return deep");
        chk("deep sx", {30'h0, d[1:0]}, 32'h3);
        tally_and_finish();
    end
endmodule : tb_top
`default_nettype wire
